//--- pkg/ssfs_defines.vh
`ifndef SSFS_DEFINES_VH
`define SSFS_DEFINES_VH

// frame format select
`define SSFS_FMT_SPI 1'b0
`define SSFS_FMT_CMD 1'b1

// word geometry
`define SSFS_WORD_MSB 4'hf
`define SSFS_WORD_ALL 16'hffff
`define SSFS_CTRL_PAD 8'h00

// edge numbering inside a frame, counted from the first clock edge
`define SSFS_EDGE_NONE 6'h00
`define SSFS_EDGE_ONE 6'h01
`define SSFS_CMD_LAST_LAUNCH 6'h10
`define SSFS_CMD_FIRST_CAP 6'h13

// bit counters
`define SSFS_CNT_ZERO 5'h00
`define SSFS_CNT_ONE 5'h01

// divider
`define SSFS_HALF_ONE 16'h0001
`define SSFS_PRESCALE_MIN 8'h02

`endif

//--- verilog/ssfs_clk_div.v
`timescale 1ns/10ps
`include "ssfs_defines.vh"

// half serial clock period tick generator
module ssfs_clk_div (
    input wire clk_sys,
    input wire rst_b,
    input wire run,
    input wire [7:0] prescale_divisor,
    input wire [7:0] serial_rate_field,
    output wire half_tick
);
    reg [15:0] cnt_reg;
    reg [15:0] half_len;
    reg [7:0] pre_eff;

    // half period = (prescale / 2) * (1 + rate); odd low bit of prescale ignored
    always @* begin
        pre_eff = (prescale_divisor < `SSFS_PRESCALE_MIN) ? `SSFS_PRESCALE_MIN
                                                          : prescale_divisor;
        half_len = {9'h000, pre_eff[7:1]} * {8'h00, serial_rate_field} +
                   {9'h000, pre_eff[7:1]};
    end

    assign half_tick = run && (cnt_reg == half_len - `SSFS_HALF_ONE);

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            cnt_reg <= 16'h0000;
        end else if (!run || half_tick) begin
            cnt_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_reg + `SSFS_HALF_ONE;
        end
    end
endmodule // ssfs_clk_div

//--- verilog/ssfs_seq.v
// Summary of operation
// - spi idle: clock at polarity level, frame select high, transmit line low.
// - idle clock pad enabled as master, disabled as slave.
// - enabled with transmit data waiting, master drops frame select, enables transmit pad.
// - mode 0/0: data half period after select falls, rising edge half later.
// - frame select returns high one clock period after the last capture.
// - phase 0 back-to-back words get a high frame select pulse between them.
// - mode 0/1: half period after select falls, data out and rising edge.
// - phase 1 back-to-back words keep frame select low throughout.
// - mode 1/0: data half period after select falls, falling edge half later.
// - mode 1/1: half period after select falls, data out and falling edge.
// - command format sends 8-bit control word first, receiving nothing meanwhile.
// - command format idle: clock low, frame select high, transmit low.
// - command frame starts on fifo data, loads shifter, MSB out at select fall.
// - control bits change on falling edges; reply latched on rising edges.
// - single command frame: select rises one period after last reply bit.
// - continuous command frames keep select low, next control byte follows directly.
// - command slave samples first bit on first rising edge after select falls.
// - words are 4 to 16 bits, most significant bit first.
// - serial clock is system clock over even prescale times rate plus one.
`timescale 1ns/10ps
`include "ssfs_defines.vh"

module ssfs_seq (
    input wire clk_sys,
    input wire rst_b,
    input wire port_enable,
    input wire master_mode,
    input wire frame_format,
    input wire clock_polarity_bit,
    input wire clock_phase_bit,
    input wire [3:0] data_size,
    input wire [7:0] prescale_divisor,
    input wire [7:0] serial_rate_field,
    input wire tx_valid,
    input wire [15:0] tx_data,
    output wire tx_ready,
    output wire rx_valid,
    output wire [15:0] rx_data,
    output wire busy,
    output wire serial_clock_line_o,
    output wire serial_clock_line_oe,
    input wire serial_clock_line_i,
    output wire frame_select_line_o,
    output wire frame_select_line_oe,
    input wire frame_select_line_i,
    output wire serial_transmit_line_o,
    output wire serial_transmit_line_oe,
    input wire serial_receive_line_i
);
    localparam ST_IDLE = 3'h0;
    localparam ST_LEAD = 3'h1;
    localparam ST_SHIFT = 3'h2;
    localparam ST_TAIL = 3'h3;
    localparam ST_END = 3'h4;

    function [3:0] ssfs_pad;
        input [3:0] dss;
        begin
            ssfs_pad = `SSFS_WORD_MSB - dss;
        end
    endfunction

    // left-align a word so that its MSB sits in bit 15
    function [15:0] ssfs_align;
        input [15:0] d;
        input [3:0] dss;
        begin
            ssfs_align = d << ssfs_pad(dss);
        end
    endfunction

    function [15:0] ssfs_mask;
        input [15:0] d;
        input [3:0] dss;
        begin
            ssfs_mask = d & (`SSFS_WORD_ALL >> ssfs_pad(dss));
        end
    endfunction

    // pin synchronisers
    reg sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
    reg fs_s1_reg, fs_s2_reg, fs_s3_reg;
    reg rxd_s1_reg, rxd_s2_reg;

    // master engine
    reg [2:0] state_reg;
    reg [5:0] ec_reg;
    reg [4:0] m_cnt_reg;
    reg [15:0] m_tx_reg;
    reg [15:0] m_rx_reg;
    reg [15:0] m_word_reg;
    reg m_push_reg;
    reg tail_reg;
    reg sclk_reg;
    reg fs_reg;
    reg m_txd_reg;

    // slave engine
    reg [4:0] s_cnt_reg;
    reg [15:0] s_tx_reg;
    reg [15:0] s_rx_reg;
    reg [15:0] s_word_reg;
    reg s_push_reg;
    reg s_loaded_reg;
    reg s_txd_reg;

    // output stage
    reg rx_valid_reg;
    reg [15:0] rx_data_reg;

    wire is_cmd = (frame_format == `SSFS_FMT_CMD);
    wire pol_eff = is_cmd ? 1'b0 : clock_polarity_bit;
    wire ph_eff = is_cmd ? 1'b0 : clock_phase_bit;
    wire master_en = port_enable && master_mode;
    wire slave_en = port_enable && !master_mode;
    wire half_tick;

    // word loaded into a shifter: control byte, or data left-aligned
    wire [15:0] ld_word = is_cmd ? {tx_data[7:0], `SSFS_CTRL_PAD}
                                 : ssfs_align(tx_data, data_size);

    wire [5:0] e_next = ec_reg + `SSFS_EDGE_ONE;
    wire spi_cap = e_next[0] ^ ph_eff;
    wire cmd_cap = e_next[0] && (e_next >= `SSFS_CMD_FIRST_CAP);
    wire cmd_launch = !e_next[0] && (e_next <= `SSFS_CMD_LAST_LAUNCH);
    wire m_cap = is_cmd ? cmd_cap : spi_cap;
    wire m_launch = is_cmd ? cmd_launch : !spi_cap;
    wire m_last = m_cap && (m_cnt_reg == {1'b0, data_size});
    wire m_cont = tx_valid && (is_cmd || ph_eff);
    wire m_start = master_en && (state_reg == ST_IDLE) && tx_valid;
    wire m_resume = master_en && (state_reg == ST_TAIL) && half_tick && !tail_reg && m_cont;

    // slave edge detection on synchronised pins
    wire s_active = slave_en && !fs_s2_reg;
    wire s_fs_fall = fs_s3_reg && !fs_s2_reg;
    wire s_edge = sclk_s2_reg != sclk_s3_reg;
    wire s_lead = s_edge && (sclk_s2_reg != pol_eff);
    wire s_trail = s_edge && (sclk_s2_reg == pol_eff);
    wire s_cap = s_active && (ph_eff ? s_trail : s_lead);
    wire s_launch = s_active && (ph_eff ? s_lead : s_trail) && (s_cnt_reg != `SSFS_CNT_ZERO);
    wire s_last = s_cap && (s_cnt_reg == {1'b0, data_size});
    wire s_fs_load = slave_en && s_fs_fall && !s_loaded_reg;
    wire s_pop = (s_fs_load || s_last) && tx_valid;
    wire [15:0] s_ld_word = tx_valid ? ld_word : 16'h0000;

    assign tx_ready = m_start || m_resume || s_pop;
    assign busy = (state_reg != ST_IDLE) || s_active;

    ssfs_clk_div u_div (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .run(master_en && (state_reg != ST_IDLE)),
        .prescale_divisor(prescale_divisor),
        .serial_rate_field(serial_rate_field),
        .half_tick(half_tick)
    );

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            sclk_s3_reg <= 1'b0;
            fs_s1_reg <= 1'b1;
            fs_s2_reg <= 1'b1;
            fs_s3_reg <= 1'b1;
            rxd_s1_reg <= 1'b0;
            rxd_s2_reg <= 1'b0;
        end else begin
            sclk_s1_reg <= serial_clock_line_i;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_s3_reg <= sclk_s2_reg;
            fs_s1_reg <= frame_select_line_i;
            fs_s2_reg <= fs_s1_reg;
            fs_s3_reg <= fs_s2_reg;
            rxd_s1_reg <= serial_receive_line_i;
            rxd_s2_reg <= rxd_s1_reg;
        end
    end

    // master frame sequencer
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            ec_reg <= `SSFS_EDGE_NONE;
            m_cnt_reg <= `SSFS_CNT_ZERO;
            m_tx_reg <= 16'h0000;
            m_rx_reg <= 16'h0000;
            m_word_reg <= 16'h0000;
            m_push_reg <= 1'b0;
            tail_reg <= 1'b0;
            sclk_reg <= 1'b0;
            fs_reg <= 1'b1;
            m_txd_reg <= 1'b0;
        end else begin
            m_push_reg <= 1'b0;
            if (!master_en) begin
                state_reg <= ST_IDLE;
                fs_reg <= 1'b1;
                sclk_reg <= pol_eff;
                m_txd_reg <= 1'b0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        fs_reg <= 1'b1;
                        sclk_reg <= pol_eff;
                        m_txd_reg <= 1'b0;
                        if (tx_valid) begin
                            fs_reg <= 1'b0;
                            m_tx_reg <= ld_word;
                            m_txd_reg <= is_cmd ? ld_word[15] : 1'b0;
                            m_cnt_reg <= `SSFS_CNT_ZERO;
                            ec_reg <= `SSFS_EDGE_NONE;
                            state_reg <= ST_LEAD;
                        end
                    end
                    ST_LEAD: begin
                        if (half_tick) begin
                            state_reg <= ST_SHIFT;
                            if (!is_cmd) begin
                                m_txd_reg <= m_tx_reg[15];
                            end
                            // phase 1 and command frames open with their first edge here
                            if (is_cmd || ph_eff) begin
                                sclk_reg <= ~sclk_reg;
                                ec_reg <= `SSFS_EDGE_ONE;
                            end
                        end
                    end
                    ST_SHIFT: begin
                        if (half_tick) begin
                            sclk_reg <= ~sclk_reg;
                            ec_reg <= e_next;
                            if (m_cap) begin
                                m_rx_reg <= {m_rx_reg[14:0], rxd_s2_reg};
                                m_cnt_reg <= m_cnt_reg + `SSFS_CNT_ONE;
                                if (m_last) begin
                                    m_word_reg <= ssfs_mask({m_rx_reg[14:0], rxd_s2_reg},
                                                            data_size);
                                    m_push_reg <= !is_cmd;
                                    tail_reg <= 1'b0;
                                    state_reg <= ST_TAIL;
                                end
                            end
                            if (m_launch) begin
                                m_tx_reg <= m_tx_reg << 1;
                                m_txd_reg <= m_tx_reg[14];
                            end
                        end
                    end
                    ST_TAIL: begin
                        if (half_tick && !tail_reg) begin
                            // closing edge back to idle for phase 0 and command frames
                            if (!ph_eff) begin
                                sclk_reg <= ~sclk_reg;
                            end
                            if (m_cont) begin
                                m_tx_reg <= ld_word;
                                m_txd_reg <= ld_word[15];
                                m_cnt_reg <= `SSFS_CNT_ZERO;
                                state_reg <= ST_SHIFT;
                                if (is_cmd) begin
                                    m_push_reg <= 1'b1;
                                    ec_reg <= `SSFS_EDGE_NONE;
                                end else begin
                                    sclk_reg <= ~sclk_reg;
                                    ec_reg <= `SSFS_EDGE_ONE;
                                end
                            end else begin
                                tail_reg <= 1'b1;
                            end
                        end else if (half_tick) begin
                            fs_reg <= 1'b1;
                            m_txd_reg <= 1'b0;
                            m_push_reg <= is_cmd;
                            state_reg <= ST_END;
                        end
                    end
                    ST_END: begin
                        // select held high a half period: the gap between phase 0 words
                        if (half_tick) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // slave shifter, clocked by edges seen on the synchronised pins
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            s_cnt_reg <= `SSFS_CNT_ZERO;
            s_tx_reg <= 16'h0000;
            s_rx_reg <= 16'h0000;
            s_word_reg <= 16'h0000;
            s_push_reg <= 1'b0;
            s_loaded_reg <= 1'b0;
            s_txd_reg <= 1'b0;
        end else begin
            s_push_reg <= 1'b0;
            if (!s_active) begin
                s_cnt_reg <= `SSFS_CNT_ZERO;
            end
            if (s_fs_load) begin
                s_tx_reg <= s_ld_word;
                s_txd_reg <= s_ld_word[15];
                s_loaded_reg <= 1'b1;
            end else if (!slave_en) begin
                s_loaded_reg <= 1'b0;
                s_txd_reg <= 1'b0;
            end
            if (s_launch) begin
                s_tx_reg <= s_tx_reg << 1;
                s_txd_reg <= s_tx_reg[14];
            end
            if (s_cap) begin
                s_rx_reg <= {s_rx_reg[14:0], rxd_s2_reg};
                s_cnt_reg <= s_cnt_reg + `SSFS_CNT_ONE;
                s_loaded_reg <= 1'b0;
                if (s_last) begin
                    s_word_reg <= ssfs_mask({s_rx_reg[14:0], rxd_s2_reg}, data_size);
                    s_push_reg <= 1'b1;
                    s_cnt_reg <= `SSFS_CNT_ZERO;
                    s_tx_reg <= s_ld_word;
                    s_txd_reg <= s_ld_word[15];
                    s_loaded_reg <= 1'b1;
                end
            end
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            rx_valid_reg <= 1'b0;
            rx_data_reg <= 16'h0000;
        end else begin
            rx_valid_reg <= m_push_reg || s_push_reg;
            if (m_push_reg) begin
                rx_data_reg <= m_word_reg;
            end else if (s_push_reg) begin
                rx_data_reg <= s_word_reg;
            end
        end
    end

    assign rx_valid = rx_valid_reg;
    assign rx_data = rx_data_reg;

    assign serial_clock_line_o = sclk_reg;
    assign serial_clock_line_oe = master_mode;
    assign frame_select_line_o = fs_reg;
    assign frame_select_line_oe = master_mode;
    assign serial_transmit_line_o = master_mode ? m_txd_reg : s_txd_reg;
    // transmit pad driven only inside a frame; the line idles low under a pull
    assign serial_transmit_line_oe = master_mode ? (master_en && !fs_reg)
                                                 : s_active;
endmodule // ssfs_seq

//--- verif/ssfs_slave_model.sv
`timescale 1ns/10ps
// off-chip slave: full duplex in spi, reply after the control byte in command format
module ssfs_slave_model (
    input wire clk_sys, input wire rst_b, input wire sclk, input wire fs_n, input wire mosi,
    input wire fmt, input wire cpha, input wire [3:0] data_size, input wire [15:0] reply,
    output reg miso_reg, output reg [15:0] got_reg, output reg got_stb_reg
);
    reg sclk_d_reg;
    reg [15:0] sr_reg;
    integer e;
    integer cnt;
    integer n;
    integer b;
    always @(posedge clk_sys) begin
        got_stb_reg <= 1'b0;
        sclk_d_reg <= sclk;
        n = data_size + 1;
        if (!rst_b) begin
            miso_reg <= 1'b0;
            e = 0;
            cnt = 0;
        end else if (fs_n) begin
            // released line without pull: keep it moving
            miso_reg <= ~miso_reg;
            e = 0;
            cnt = 0;
        end else begin
            if (sclk != sclk_d_reg) begin
                e = e + 1;
                if (fmt ? (e % 2 == 1 && e < 16) : ((e % 2 == 1) != cpha)) begin
                    sr_reg = {sr_reg[14:0], mosi};
                    cnt = cnt + 1;
                    if (cnt == (fmt ? 8 : n)) begin
                        got_reg <= fmt ? (sr_reg & 16'h00ff) : (sr_reg & ~(16'hffff << n));
                        got_stb_reg <= 1'b1;
                        cnt = 0;
                    end
                end
                if (!fmt && cpha && e > 2 * n)
                    e = 1;
                if (fmt && e == 18 + 2 * n)
                    e = 0;
            end
            b = fmt ? (e - 18) / 2 : (cpha ? (e == 0 ? 0 : (e - 1) / 2) : e / 2);
            if ((fmt && e < 18) || b >= n)
                miso_reg <= ~miso_reg;
            else
                miso_reg <= reply[n - 1 - b];
        end
    end
endmodule // ssfs_slave_model

//--- verif/ssfs_seq_chk.sv
`timescale 1ns/10ps
module ssfs_seq_chk (
    input wire clk_sys, input wire rst_b, input wire port_enable, input wire master_mode,
    input wire frame_format, input wire clock_polarity_bit, input wire clock_phase_bit,
    input wire [3:0] data_size, input wire [7:0] prescale_divisor,
    input wire [7:0] serial_rate_field, input wire tx_valid, input wire tx_ready,
    input wire rx_valid, input wire [15:0] rx_data, input wire serial_clock_line_o,
    input wire serial_clock_line_oe, input wire frame_select_line_o,
    input wire serial_transmit_line_o, input wire serial_transmit_line_oe
);
    reg sclk_d_reg;
    reg fs_d_reg;
    reg seen_reg;
    reg [1:0] live_reg;
    reg [15:0] ecnt_reg;
    reg [15:0] fcnt_reg;
    wire [6:0] pre = prescale_divisor[7:1];
    wire [15:0] half = (pre == 7'h00 ? 16'h0001 : {9'h000, pre}) * ({8'h00, serial_rate_field} + 16'h0001);
    wire sclk_edge = serial_clock_line_o != sclk_d_reg;
    wire fs_fall = fs_d_reg && !frame_select_line_o;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // ecnt: cycles since the last clock pin change, fcnt: cycles since select fell
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            sclk_d_reg <= 1'b0;
            fs_d_reg <= 1'b1;
            seen_reg <= 1'b0;
            live_reg <= 2'h0;
            ecnt_reg <= 16'hffff;
            fcnt_reg <= 16'h0000;
        end else begin
            sclk_d_reg <= serial_clock_line_o;
            fs_d_reg <= frame_select_line_o;
            live_reg <= {live_reg[0], 1'b1};
            ecnt_reg <= sclk_edge ? 16'h0001 : ecnt_reg + {15'h0000, ecnt_reg != 16'hffff};
            fcnt_reg <= fs_fall ? 16'h0001 : fcnt_reg + {15'h0000, fcnt_reg != 16'hffff};
            seen_reg <= !fs_fall && (seen_reg || (sclk_edge && !frame_select_line_o));
        end
    end
    idle_levels_a: assert property (
        master_mode && port_enable && $past(port_enable) && live_reg[1] && frame_select_line_o
        && $past(frame_select_line_o) |-> !serial_transmit_line_o && !serial_transmit_line_oe
        && serial_clock_line_o == (frame_format ? 1'b0 : clock_polarity_bit))
        else $error("idle pin levels wrong");
    clk_pad_a: assert property (serial_clock_line_oe == master_mode)
        else $error("clock pad enable wrong");
    frame_start_a: assert property (
        master_mode && port_enable && frame_select_line_o && tx_valid && tx_ready
        |=> !frame_select_line_o && serial_transmit_line_oe)
        else $error("frame did not start");
    first_edge_a: assert property (
        master_mode && !frame_format && !frame_select_line_o && sclk_edge && !seen_reg
        |-> fcnt_reg == (clock_phase_bit ? half : {half[14:0], 1'b0}))
        else $error("first clock edge misplaced");
    edge_spacing_a: assert property (
        master_mode && !frame_select_line_o && sclk_edge && seen_reg |-> ecnt_reg == half)
        else $error("serial clock rate wrong");
    frame_end_a: assert property (
        master_mode && $rose(frame_select_line_o)
        |-> ecnt_reg == ((!frame_format && clock_phase_bit) ? {half[14:0], 1'b0} : half))
        else $error("select rose at wrong time");
    ph0_gap_a: assert property (
        master_mode && !frame_format && !clock_phase_bit && $rose(frame_select_line_o)
        |-> frame_select_line_o [*4])
        else $error("select gap too short");
    burst_low_a: assert property (
        master_mode && !frame_select_line_o && tx_valid && tx_ready
        && (clock_phase_bit || frame_format) |=> !frame_select_line_o [*8])
        else $error("select left burst");
    rx_pulse_a: assert property (rx_valid |=> !rx_valid)
        else $error("receive strobe too long");
    rx_width_a: assert property (
        rx_valid |-> (rx_data & (16'hffff << ({1'b0, data_size} + 5'h01))) == 16'h0000)
        else $error("receive word too wide");
    cmd_rx_c: cover property (rx_valid && frame_format);
    burst_c: cover property (master_mode && !frame_select_line_o && tx_valid && tx_ready);
    ph0_end_c: cover property ($rose(frame_select_line_o) && !clock_phase_bit && !frame_format);
endmodule // ssfs_seq_chk

bind ssfs_seq ssfs_seq_chk u_ssfs_seq_chk (.clk_sys(clk_sys), .rst_b(rst_b),
    .port_enable(port_enable), .master_mode(master_mode), .frame_format(frame_format),
    .clock_polarity_bit(clock_polarity_bit), .clock_phase_bit(clock_phase_bit),
    .data_size(data_size), .prescale_divisor(prescale_divisor),
    .serial_rate_field(serial_rate_field), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .serial_clock_line_o(serial_clock_line_o),
    .serial_clock_line_oe(serial_clock_line_oe), .frame_select_line_o(frame_select_line_o),
    .serial_transmit_line_o(serial_transmit_line_o),
    .serial_transmit_line_oe(serial_transmit_line_oe));

//--- verif/tb_sync_serial_frame_sequencer.sv
`timescale 1ns/10ps
module tb_sync_serial_frame_sequencer;
    reg clk_sys = 1'b0;
    reg rst_b = 1'b0;
    reg port_enable = 1'b0;
    reg master_mode = 1'b1;
    reg frame_format = 1'b0;
    reg clock_polarity_bit = 1'b0;
    reg clock_phase_bit = 1'b0;
    reg [3:0] data_size = 4'h7;
    reg [7:0] prescale_divisor = 8'h02;
    reg [7:0] serial_rate_field = 8'h02;
    reg tx_valid = 1'b0;
    reg [15:0] tx_data = 16'h0000;
    reg [15:0] reply = 16'h0000;
    reg [15:0] exp_rx[$];
    reg [15:0] exp_tx[$];
    wire tx_ready, rx_valid, busy, sclk_o, sclk_oe, fs_o, fs_oe, txd_o, txd_oe, miso, got_stb;
    wire [15:0] rx_data, got_word;
    integer seed = 51;
    integer n_errors = 0;
    integer checks = 0;
    integer m;
    ssfs_seq u_ssfs_seq (.clk_sys(clk_sys), .rst_b(rst_b), .port_enable(port_enable),
        .master_mode(master_mode), .frame_format(frame_format),
        .clock_polarity_bit(clock_polarity_bit), .clock_phase_bit(clock_phase_bit),
        .data_size(data_size), .prescale_divisor(prescale_divisor),
        .serial_rate_field(serial_rate_field), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .busy(busy),
        .serial_clock_line_o(sclk_o), .serial_clock_line_oe(sclk_oe),
        .serial_clock_line_i(1'b0), .frame_select_line_o(fs_o), .frame_select_line_oe(fs_oe),
        .frame_select_line_i(1'b1), .serial_transmit_line_o(txd_o),
        .serial_transmit_line_oe(txd_oe), .serial_receive_line_i(miso));
    ssfs_slave_model u_ssfs_slave_model (.clk_sys(clk_sys), .rst_b(rst_b), .sclk(sclk_o),
        .fs_n(fs_o), .mosi(txd_oe ? txd_o : 1'bz), .fmt(frame_format), .cpha(clock_phase_bit),
        .data_size(data_size), .reply(reply), .miso_reg(miso), .got_reg(got_word),
        .got_stb_reg(got_stb));
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    task check_word(input [8*8-1:0] name, input [15:0] exp, input [15:0] got);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("[ERR] %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task summarize;
        begin
            $display("checks %0d errors %0d", checks, n_errors);
            if (n_errors == 0 && checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    always @(negedge clk_sys) begin
        if (rx_valid === 1'b1)
            check_word("rx_data", exp_rx.size() > 0 ? exp_rx.pop_front() : ~rx_data, rx_data);
        if (got_stb === 1'b1)
            check_word("tx_word", exp_tx.size() > 0 ? exp_tx.pop_front() : ~got_word, got_word);
    end
    // two words per test, second word held ready for back-to-back transfer
    task run_test(input reg f, input reg p, input reg h);
        integer k;
        integer t;
        reg [15:0] w;
        begin
            @(posedge clk_sys);
            port_enable <= 1'b0;
            @(posedge clk_sys);
            frame_format <= f;
            clock_polarity_bit <= p;
            clock_phase_bit <= h;
            data_size <= 4'h3 + $unsigned($random(seed)) % 13;
            prescale_divisor <= $random(seed) & 8'h04 | 8'h02;
            // half period of four or more: the slave model answers one cycle after each edge
            serial_rate_field <= 8'h03 + ($random(seed) & 3);
            reply <= $random(seed);
            repeat (4) @(posedge clk_sys);
            port_enable <= 1'b1;
            for (k = 0; k < 2; k = k + 1) begin
                w = $random(seed);
                exp_tx.push_back(f ? w & 16'h00ff : w & ~(16'hffff << (data_size + 1)));
                exp_rx.push_back(reply & ~(16'hffff << (data_size + 1)));
                tx_data <= w;
                tx_valid <= 1'b1;
                t = 0;
                @(negedge clk_sys);
                while (tx_ready !== 1'b1 && t < 9000) begin
                    @(negedge clk_sys);
                    t = t + 1;
                end
                @(posedge clk_sys);
            end
            tx_valid <= 1'b0;
            t = 0;
            while ((exp_rx.size() + exp_tx.size() > 0 || busy !== 1'b0) && t < 9000) begin
                @(negedge clk_sys);
                t = t + 1;
            end
            repeat (3) @(negedge clk_sys);
            check_word("pending", 16'h0000, 16'(exp_rx.size() + exp_tx.size()));
            check_word("fs_idle", 16'h0001, {15'h0000, fs_o});
            check_word("clk_idle", {15'h0000, p & !f}, {15'h0000, sclk_o});
            check_word("clk_pad", 16'h0001, {15'h0000, sclk_oe});
            check_word("tx_idle", 16'h0000, {15'h0000, txd_o});
            check_word("fs_pad", 16'h0001, {15'h0000, fs_oe});
            check_word("busy", 16'h0000, {15'h0000, busy});
            $display("test done fmt %0d pol %0d pha %0d", f, p, h);
        end
    endtask
    initial begin
        #200000;
        n_errors = n_errors + 1;
        $display("[ERR] watchdog expected done seen hang");
        summarize;
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        master_mode <= 1'b0;
        @(negedge clk_sys);
        check_word("clk_pad", 16'h0000, {15'h0000, sclk_oe});
        check_word("fs_pad", 16'h0000, {15'h0000, fs_oe});
        @(posedge clk_sys);
        master_mode <= 1'b1;
        // four spi modes, then command format with the phase bit clear and set
        for (m = 0; m < 6; m = m + 1)
            run_test(m > 3, m[1] ^ m[2], m[0]);
        summarize;
    end
endmodule // tb_sync_serial_frame_sequencer
